// >>> hw/msw1_top.v
// startup configuration word with wishbone access and startup sequencer
// How it works
// R01: 32-bit read/write word at 84h, every field resets to zero.
// R02: bits 30-29 pick single align, double align, position probe or slow cycle.
// R03: bits 28-25 set current ramp rate; code F removes the limit.
// R04: bits 24-21 set alignment duration, 10 ms up to 10 s.
// R05: bits 20-17 set align or slow-cycle current limit code.
// R06: bits 16-14 pick probe clock rate, 50 Hz up to 10000 Hz.
// R07: bits 5-4 run position probing once, or two to four times averaged.
// R08: bit 2 set adds torque current ramp-down before closed loop handoff.
// R09: bit 1 enables active braking.
// R10: bit 31 is stored as a plain read/write bit.
//
// The Wishbone register port was chosen for this implementation.
`timescale 1ns/1ns
`default_nettype none
`include "msw1_map.vh"

module msw1_top #(
  parameter integer CLK_HZ = `MSW1_CLK_HZ
) (
  input wire clock,
  input wire rst_n,
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_we_i,
  input wire [7:0] wb_adr_i,
  input wire [3:0] wb_sel_i,
  input wire [31:0] wb_dat_i,
  output reg [31:0] wb_dat_o,
  output reg wb_ack_o,
  output wire parityBit,
  output wire [1:0] startupMethodSel,
  output wire [3:0] rampRateCode,
  output reg rampUnlimited,
  output wire [3:0] alignTimeCode,
  output wire [3:0] startupCurrentCapCode,
  output wire [2:0] positionProbeClockCode,
  output wire [4:0] positionProbeCurrentThreshold,
  output wire positionProbeReleaseSel,
  output wire [1:0] positionProbeAdvanceAngle,
  output wire [1:0] positionProbeRepeatCount,
  output wire openloopCurrentCapSource,
  output wire torqueCurrentRampdownEn,
  output wire activeBrakeEn,
  output wire reverseDriveSettingSel,
  output reg [2:0] startupPhase,
  output reg alignCurrentActive,
  output reg torqueRampdownActive,
  output wire probeTick
);

  localparam [2:0] PH_IDLE = 3'h0;
  localparam [2:0] PH_ALIGN = 3'h1;
  localparam [2:0] PH_PROBE = 3'h2;
  localparam [2:0] PH_SLOW = 3'h3;
  localparam [2:0] PH_RAMPDN = 3'h4;
  localparam [2:0] PH_DONE = 3'h5;
  localparam [31:0] MS_CYCLES = CLK_HZ / `MSW1_MS_PER_S;

  reg [31:0] startupWord;
  reg [31:0] msCount;
  reg msTick;
  reg [13:0] alignLeft;
  reg secondPass;
  reg [1:0] probeLeft;
  reg [15:0] probeTickCount;
  reg [2:0] next_phase;

  wire wbReq = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  wire wbWrite = wbReq & wb_we_i;
  wire ctrlWrite = wbWrite & (wb_adr_i == `MSW1_ADDR_CTRL) & wb_sel_i[0];
  wire startReq = ctrlWrite & wb_dat_i[`MSW1_CTRL_START_BIT];
  wire abortReq = ctrlWrite & wb_dat_i[`MSW1_CTRL_ABORT_BIT];
  wire phaseEnds;
  wire startTaken;
  wire rampdownEntry;
  wire msRestart;

  // field views straight off the stored word
  assign parityBit = startupWord[`MSW1_PARITY_BIT]; // R10
  assign startupMethodSel =
    startupWord[`MSW1_METHOD_MSB:`MSW1_METHOD_LSB];
  assign rampRateCode = startupWord[`MSW1_RAMP_MSB:`MSW1_RAMP_LSB];
  assign alignTimeCode = startupWord[`MSW1_ALIGN_MSB:`MSW1_ALIGN_LSB];
  assign startupCurrentCapCode =
    startupWord[`MSW1_CAP_MSB:`MSW1_CAP_LSB]; // R05
  assign positionProbeClockCode =
    startupWord[`MSW1_PCLK_MSB:`MSW1_PCLK_LSB];
  assign positionProbeCurrentThreshold =
    startupWord[`MSW1_PTHR_MSB:`MSW1_PTHR_LSB];
  assign positionProbeReleaseSel = startupWord[`MSW1_RELEASE_BIT];
  assign positionProbeAdvanceAngle =
    startupWord[`MSW1_ADV_MSB:`MSW1_ADV_LSB];
  assign positionProbeRepeatCount =
    startupWord[`MSW1_REPEAT_MSB:`MSW1_REPEAT_LSB];
  assign openloopCurrentCapSource = startupWord[`MSW1_OLCAP_BIT];
  assign torqueCurrentRampdownEn = startupWord[`MSW1_IQRAMP_BIT];
  assign activeBrakeEn = startupWord[`MSW1_BRAKE_BIT]; // R09
  assign reverseDriveSettingSel = startupWord[`MSW1_REVDRV_BIT];

  // alignment duration in milliseconds per code
  function [13:0] alignMs;
    input [3:0] code;
    begin
      case (code)
        4'h0: alignMs = 14'd10;
        4'h1: alignMs = 14'd50;
        4'h2: alignMs = 14'd100;
        4'h3: alignMs = 14'd200;
        4'h4: alignMs = 14'd300;
        4'h5: alignMs = 14'd400;
        4'h6: alignMs = 14'd500;
        4'h7: alignMs = 14'd750;
        4'h8: alignMs = 14'd1000;
        4'h9: alignMs = 14'd1500;
        4'hA: alignMs = 14'd2000;
        4'hB: alignMs = 14'd3000;
        4'hC: alignMs = 14'd4000;
        4'hD: alignMs = 14'd5000;
        4'hE: alignMs = 14'd7500;
        4'hF: alignMs = 14'd10000;
        default: alignMs = 14'd10;
      endcase
    end
  endfunction

  // byte-lane merge for a wishbone write
  function [31:0] mergeBytes;
    input [31:0] oldWord;
    input [31:0] newWord;
    input [3:0] sel;
    integer i;
    begin
      mergeBytes = oldWord;
      for (i = 0; i < 4; i = i + 1) begin
        if (sel[i]) begin
          mergeBytes[i*8 +: 8] = newWord[i*8 +: 8];
        end
      end
    end
  endfunction

  // wishbone slave: one wait state, ack for exactly one cycle
  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h00000000;
    end else if (wbReq) begin
      wb_ack_o <= 1'b1;
      case (wb_adr_i)
        `MSW1_ADDR_STARTUP1: wb_dat_o <= startupWord; // R01
        `MSW1_ADDR_STATUS: begin
          wb_dat_o <= {probeTickCount, 12'h000,
                       startupPhase == PH_DONE, startupPhase};
        end
        default: wb_dat_o <= 32'h00000000;
      endcase
    end else begin
      wb_ack_o <= 1'b0;
    end
  end

  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      startupWord <= `MSW1_RESET_STARTUP1; // R01
    end else if (wbWrite && wb_adr_i == `MSW1_ADDR_STARTUP1) begin
      startupWord <= mergeBytes(startupWord, wb_dat_i, wb_sel_i); // R01
    end
  end

  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      rampUnlimited <= 1'b0;
    end else begin
      rampUnlimited <= (rampRateCode == `MSW1_RAMP_NO_LIMIT); // R03
    end
  end

  // millisecond base, restarted on a taken start or rampdown entry only,
  // so a refused start cannot stretch a running phase
  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      msCount <= 32'h00000000;
      msTick <= 1'b0;
    end else if (MS_CYCLES <= 32'h00000001) begin
      msCount <= 32'h00000000;
      msTick <= ~msRestart;
    end else if (msRestart) begin
      // the restart edge is already the first cycle of the new ms
      msCount <= 32'h00000001;
      msTick <= 1'b0;
    end else if (msCount == MS_CYCLES - 32'h00000001) begin
      msCount <= 32'h00000000;
      msTick <= 1'b1;
    end else begin
      msCount <= msCount + 32'h00000001;
      msTick <= 1'b0;
    end
  end

  msw1_probe_clock #(
    .CLK_HZ(CLK_HZ)
  ) probeClock (
    .clock(clock),
    .rst_n(rst_n),
    .enable(startupPhase == PH_PROBE),
    .rateCode(positionProbeClockCode),
    .tick(probeTick)
  );

  assign phaseEnds =
    ((startupPhase == PH_ALIGN || startupPhase == PH_SLOW) &&
     msTick && alignLeft == 14'd1) ||
    (startupPhase == PH_PROBE && probeTick && probeLeft == 2'h0) ||
    (startupPhase == PH_RAMPDN && msTick);

  // a start is only taken from idle or done; abort wins in the same write
  assign startTaken = startReq & ~abortReq &
    (startupPhase == PH_IDLE || startupPhase == PH_DONE);
  // rampdown gets a fresh ms base so it lasts a whole ms after probing too
  assign rampdownEntry = (next_phase == PH_RAMPDN) &&
    (startupPhase != PH_RAMPDN);
  assign msRestart = startTaken | rampdownEntry;

  // phase sequencing; abort beats a start in the same write
  always @* begin
    next_phase = startupPhase;
    if (abortReq) begin
      next_phase = PH_IDLE;
    end else if (startReq &&
                 (startupPhase == PH_IDLE || startupPhase == PH_DONE)) begin
      case (startupMethodSel) // R02
        `MSW1_METHOD_ALIGN: next_phase = PH_ALIGN;
        `MSW1_METHOD_DOUBLE: next_phase = PH_ALIGN;
        `MSW1_METHOD_PROBE: next_phase = PH_PROBE;
        `MSW1_METHOD_SLOW: next_phase = PH_SLOW;
        default: next_phase = PH_ALIGN;
      endcase
    end else if (phaseEnds) begin
      case (startupPhase)
        PH_ALIGN: begin
          if (secondPass) begin
            next_phase = PH_ALIGN; // R02
          end else if (torqueCurrentRampdownEn) begin
            next_phase = PH_RAMPDN; // R08
          end else begin
            next_phase = PH_DONE; // R08
          end
        end
        PH_PROBE, PH_SLOW: begin
          if (torqueCurrentRampdownEn) begin
            next_phase = PH_RAMPDN; // R08
          end else begin
            next_phase = PH_DONE; // R08
          end
        end
        PH_RAMPDN: next_phase = PH_DONE;
        default: next_phase = startupPhase;
      endcase
    end
  end

  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      startupPhase <= PH_IDLE;
      alignLeft <= 14'd0;
      secondPass <= 1'b0;
      probeLeft <= 2'h0;
      probeTickCount <= 16'h0000;
      alignCurrentActive <= 1'b0;
      torqueRampdownActive <= 1'b0;
    end else begin
      startupPhase <= next_phase;
      alignCurrentActive <=
        (next_phase == PH_ALIGN || next_phase == PH_SLOW); // R05
      torqueRampdownActive <= (next_phase == PH_RAMPDN); // R08
      if (!abortReq && startReq &&
          (startupPhase == PH_IDLE || startupPhase == PH_DONE)) begin
        alignLeft <= alignMs(alignTimeCode); // R04
        secondPass <= (startupMethodSel == `MSW1_METHOD_DOUBLE); // R02
        probeLeft <= positionProbeRepeatCount; // R07
        probeTickCount <= 16'h0000;
      end else begin
        if (phaseEnds && startupPhase == PH_ALIGN) begin
          alignLeft <= alignMs(alignTimeCode); // R04
          secondPass <= 1'b0;
        end else if (msTick && alignLeft != 14'd0 &&
                     (startupPhase == PH_ALIGN ||
                      startupPhase == PH_SLOW)) begin
          alignLeft <= alignLeft - 14'd1; // R04
        end
        if (probeTick && startupPhase == PH_PROBE) begin
          probeTickCount <= probeTickCount + 16'h0001;
          if (probeLeft != 2'h0) begin
            probeLeft <= probeLeft - 2'h1; // R07
          end
        end
      end
    end
  end

endmodule // msw1_top

`default_nettype wire

// >>> pkg/msw1_map.vh
// register map, field positions and timing constants of the startup word
`ifndef MSW1_MAP_VH
`define MSW1_MAP_VH

`define MSW1_ADDR_STARTUP1 8'h84
`define MSW1_ADDR_CTRL 8'hC0
`define MSW1_ADDR_STATUS 8'hC4
`define MSW1_RESET_STARTUP1 32'h00000000
`define MSW1_RESET_STATUS 32'h00000000

`define MSW1_PARITY_BIT 31
`define MSW1_METHOD_MSB 30
`define MSW1_METHOD_LSB 29
`define MSW1_RAMP_MSB 28
`define MSW1_RAMP_LSB 25
`define MSW1_ALIGN_MSB 24
`define MSW1_ALIGN_LSB 21
`define MSW1_CAP_MSB 20
`define MSW1_CAP_LSB 17
`define MSW1_PCLK_MSB 16
`define MSW1_PCLK_LSB 14
`define MSW1_PTHR_MSB 13
`define MSW1_PTHR_LSB 9
`define MSW1_RELEASE_BIT 8
`define MSW1_ADV_MSB 7
`define MSW1_ADV_LSB 6
`define MSW1_REPEAT_MSB 5
`define MSW1_REPEAT_LSB 4
`define MSW1_OLCAP_BIT 3
`define MSW1_IQRAMP_BIT 2
`define MSW1_BRAKE_BIT 1
`define MSW1_REVDRV_BIT 0

`define MSW1_METHOD_ALIGN 2'h0
`define MSW1_METHOD_DOUBLE 2'h1
`define MSW1_METHOD_PROBE 2'h2
`define MSW1_METHOD_SLOW 2'h3
`define MSW1_RAMP_NO_LIMIT 4'hF

`define MSW1_CTRL_START_BIT 0
`define MSW1_CTRL_ABORT_BIT 1
`define MSW1_STAT_PHASE_MSB 2
`define MSW1_STAT_DONE_BIT 3
`define MSW1_STAT_TICKS_LSB 16

`define MSW1_CLK_HZ 250000000
`define MSW1_MS_PER_S 1000

`endif

// >>> hw/msw1_probe_clock.v
// position probe clock: one-cycle tick at the rate chosen by a 3-bit code
`timescale 1ns/1ns
`default_nettype none
`include "msw1_map.vh"

module msw1_probe_clock #(
  parameter integer CLK_HZ = `MSW1_CLK_HZ
) (
  input wire clock,
  input wire rst_n,
  input wire enable,
  input wire [2:0] rateCode,
  output reg tick
);

  reg [31:0] count;

  // cycles per probe clock period for each rate code
  function [31:0] periodCycles;
    input [2:0] code;
    reg [31:0] hz;
    begin
      hz = 32'h00000032;
      case (code)
        3'h0: hz = 32'd50;
        3'h1: hz = 32'd100;
        3'h2: hz = 32'd250;
        3'h3: hz = 32'd500;
        3'h4: hz = 32'd1000;
        3'h5: hz = 32'd2000;
        3'h6: hz = 32'd5000;
        3'h7: hz = 32'd10000;
        default: hz = 32'd50;
      endcase
      periodCycles = CLK_HZ / hz;
      if (periodCycles == 32'h00000000) begin
        periodCycles = 32'h00000001;
      end
    end
  endfunction

  // counting from zero at enable keeps the first tick a full period away
  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      count <= 32'h00000000;
      tick <= 1'b0;
    end else if (!enable) begin
      count <= 32'h00000000;
      tick <= 1'b0;
    end else if (count >= periodCycles(rateCode) - 32'h00000001) begin
      count <= 32'h00000000;
      tick <= 1'b1; // R06
    end else begin
      count <= count + 32'h00000001;
      tick <= 1'b0;
    end
  end

endmodule // msw1_probe_clock

`default_nettype wire

// >>> testbench/msw1_top_asserts.sv
// assertion checker for the startup word block
`timescale 1ns/1ns
`default_nettype none
module msw1_top_asserts #(
  parameter integer CLK_HZ = 250000000
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_ack_o,
  input wire logic [3:0] rampRateCode,
  input wire logic rampUnlimited,
  input wire logic torqueCurrentRampdownEn,
  input wire logic [2:0] startupPhase,
  input wire logic alignCurrentActive,
  input wire logic torqueRampdownActive,
  input wire logic probeTick
);
  localparam int MS = CLK_HZ / 1000;
  int rdCnt;
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);
  // a counter, since one ms is far too long for a delay at full clock rate
  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) rdCnt <= 0;
    else if (startupPhase == 3'h4) rdCnt <= rdCnt + 1;
    else rdCnt <= 0;
  end
  a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  a_ack_answer: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("request not acknowledged");
  a_ramp_flag: assert property (1'b1 |=> rampUnlimited == $past(rampRateCode == 4'hF))
    else $error("unlimited ramp flag wrong");
  a_align_drive: assert property (alignCurrentActive ==
    (startupPhase == 3'h1 || startupPhase == 3'h3))
    else $error("align current flag wrong");
  a_rampdown_gate: assert property (startupPhase == 3'h4 |-> torqueCurrentRampdownEn)
    else $error("rampdown without enable");
  a_rampdown_flag: assert property (torqueRampdownActive ==
    (startupPhase == 3'h4))
    else $error("rampdown flag wrong");
  a_rampdown_short: assert property (startupPhase == 3'h4 |-> rdCnt < MS)
    else $error("rampdown too long");
  a_rampdown_full: assert property ($fell(startupPhase == 3'h4) &&
    startupPhase == 3'h5 |-> rdCnt == MS)
    else $error("rampdown too short");
  a_tick_pulse: assert property (probeTick |=> !probeTick)
    else $error("probe tick wider than one cycle");
  a_tick_phase: assert property (probeTick |-> startupPhase == 3'h2 || $past(startupPhase) == 3'h2)
    else $error("probe tick outside probing");
  cover property (startupPhase == 3'h4);
  cover property (probeTick);
  cover property (rampUnlimited);
endmodule // msw1_top_asserts
bind msw1_top msw1_top_asserts #(.CLK_HZ(CLK_HZ)) chk_u (.clock, .rst_n,
  .wb_cyc_i, .wb_stb_i, .wb_ack_o, .rampRateCode, .rampUnlimited,
  .torqueCurrentRampdownEn, .startupPhase, .alignCurrentActive,
  .torqueRampdownActive, .probeTick);
`default_nettype wire

// >>> testbench/msw1_top_test.sv
// self-checking bench for the startup configuration word
`timescale 1ns/1ns
`default_nettype none
`include "msw1_map.vh"
module msw1_top_test;
  // small clock rate keeps align times short: one ms is MS cycles
  localparam integer CLK_HZ = 100000;
  localparam int MS = CLK_HZ / 1000;
  logic clock = 0, rst_n = 0, wbCyc = 0, wbStb = 0, wbWe = 0;
  logic [7:0] wbAdr = 8'h00;
  logic [3:0] wbSel = 4'h0;
  logic [31:0] wbDat = 32'h00000000, rd;
  wire [31:0] wbDatO, fields;
  wire wbAck, parityBit, rampUnlimited, positionProbeReleaseSel, probeTick;
  wire openloopCurrentCapSource, torqueCurrentRampdownEn, activeBrakeEn;
  wire reverseDriveSettingSel, alignCurrentActive, torqueRampdownActive;
  wire [1:0] startupMethodSel, positionProbeAdvanceAngle;
  wire [1:0] positionProbeRepeatCount;
  wire [3:0] rampRateCode, alignTimeCode, startupCurrentCapCode;
  wire [2:0] positionProbeClockCode, startupPhase;
  wire [4:0] positionProbeCurrentThreshold;
  int mismatches = 0, compares = 0;
  logic [31:0] words [4] = '{32'hFFFFFFFF, 32'hA5A5A5A5, 32'h5A5A5A5A,
    32'h12345678};
  always #2 clock = ~clock;
  msw1_top #(.CLK_HZ(CLK_HZ)) dut_u (.clock, .rst_n, .wb_cyc_i(wbCyc),
    .wb_stb_i(wbStb), .wb_we_i(wbWe), .wb_adr_i(wbAdr), .wb_sel_i(wbSel),
    .wb_dat_i(wbDat), .wb_dat_o(wbDatO), .wb_ack_o(wbAck), .parityBit,
    .startupMethodSel, .rampRateCode, .rampUnlimited, .alignTimeCode,
    .startupCurrentCapCode, .positionProbeClockCode,
    .positionProbeCurrentThreshold, .positionProbeReleaseSel,
    .positionProbeAdvanceAngle, .positionProbeRepeatCount,
    .openloopCurrentCapSource, .torqueCurrentRampdownEn, .activeBrakeEn,
    .reverseDriveSettingSel, .startupPhase, .alignCurrentActive,
    .torqueRampdownActive, .probeTick);
  assign fields = {parityBit, startupMethodSel, rampRateCode, alignTimeCode,
    startupCurrentCapCode, positionProbeClockCode,
    positionProbeCurrentThreshold, positionProbeReleaseSel,
    positionProbeAdvanceAngle, positionProbeRepeatCount,
    openloopCurrentCapSource, torqueCurrentRampdownEn, activeBrakeEn,
    reverseDriveSettingSel};
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      mismatches++;
      $display("Error t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wbXfer(input logic we, input logic [7:0] a,
    input logic [3:0] s, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clock);
    wbCyc <= 1'b1;
    wbStb <= 1'b1;
    wbWe <= we;
    wbAdr <= a;
    wbSel <= s;
    wbDat <= d;
    do begin
      @(posedge clock);
      n++;
    end while (wbAck !== 1'b1 && n < 100);
    check({31'h0, wbAck}, 32'h1);
    rd = wbDatO;
    wbCyc <= 1'b0;
    wbStb <= 1'b0;
  endtask
  // cycles is counted from the ack of the start write; 0 skips that check
  task automatic startRun(input logic [31:0] w, input int cycles,
    input logic [15:0] ticks);
    int n;
    n = 0;
    wbXfer(1'b1, `MSW1_ADDR_STARTUP1, 4'hF, w);
    wbXfer(1'b1, `MSW1_ADDR_CTRL, 4'hF, 32'h1);
    while (startupPhase !== 3'h5 && n < 20000) begin
      @(posedge clock);
      n++;
    end
    if (cycles > 0) check(32'(n), 32'(cycles));
    wbXfer(1'b0, `MSW1_ADDR_STATUS, 4'hF, 32'h0);
    check({rd[31:16], rd[3:0]}, {ticks, 4'hD});
    $display("test run %h done", w);
  endtask
  task automatic final_report;
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  initial begin
    #(4 * 40000);
    mismatches++;
    final_report();
  end
  initial begin
    repeat (10) @(posedge clock);
    rst_n <= 1'b1;
    wbXfer(1'b0, `MSW1_ADDR_STARTUP1, 4'hF, 32'h0);
    check(rd, `MSW1_RESET_STARTUP1);
    check(fields, 32'h0);
    wbXfer(1'b0, 8'h10, 4'hF, 32'h0);
    check(rd, 32'h0);
    $display("test reset done");
    foreach (words[i]) begin
      wbXfer(1'b1, `MSW1_ADDR_STARTUP1, 4'hF, words[i]);
      wbXfer(1'b0, `MSW1_ADDR_STARTUP1, 4'hF, 32'h0);
      check(rd, words[i]);
      check(fields, words[i]);
      check({31'h0, rampUnlimited}, {31'h0, words[i][28:25] == 4'hF});
    end
    wbXfer(1'b1, `MSW1_ADDR_STARTUP1, 4'h2, 32'hFFFFFFFF);
    wbXfer(1'b0, `MSW1_ADDR_STARTUP1, 4'hF, 32'h0);
    check(rd, 32'h1234FF78);
    $display("test fields done");
    startRun(32'h00200000, 50 * MS, 16'h0);
    startRun(32'h20000004, 21 * MS, 16'h0);
    startRun(32'h60000000, 10 * MS, 16'h0);
    startRun(32'h4001C030, 0, 16'h4);
    // a long align: a second start is refused, then abort returns to idle
    wbXfer(1'b1, `MSW1_ADDR_STARTUP1, 4'hF, 32'h01E00000);
    wbXfer(1'b1, `MSW1_ADDR_CTRL, 4'hF, 32'h1);
    wbXfer(1'b1, `MSW1_ADDR_CTRL, 4'hF, 32'h1);
    wbXfer(1'b0, `MSW1_ADDR_STATUS, 4'hF, 32'h0);
    check(rd, 32'h00000001);
    wbXfer(1'b1, `MSW1_ADDR_STATUS, 4'hF, 32'hFFFFFFFF);
    wbXfer(1'b1, `MSW1_ADDR_CTRL, 4'hF, 32'h3);
    wbXfer(1'b0, `MSW1_ADDR_STATUS, 4'hF, 32'h0);
    check(rd, 32'h00000000);
    wbXfer(1'b0, `MSW1_ADDR_CTRL, 4'hF, 32'h0);
    check(rd, 32'h00000000);
    $display("test abort done");
    final_report();
  end
endmodule // msw1_top_test
`default_nettype wire
